// ==== verilog/tbc_pkg.sv ====
// constants, register map and types for the time base counter block
package tbc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 1000;
    localparam int CYC_DIV = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int RST_SHORT_CYC = 3;
    localparam int RST_LONG_CYC = 10;
    localparam int PRE_BITS = 2;
    localparam int T_BITS = 8;

    localparam logic [11:0] ADDR_ENABLE = 12'h000;
    localparam logic [11:0] ADDR_TIMER = 12'h004;
    localparam logic [11:0] ADDR_TSTCLR = 12'h008;
    localparam logic [11:0] ADDR_PORTS = 12'h00C;
    localparam logic [11:0] ADDR_QREG = 12'h010;
    localparam logic [11:0] ADDR_INLATCH = 12'h014;
    localparam logic [11:0] ADDR_INT_STAT = 12'h018;
    localparam logic [11:0] ADDR_INT_CLR = 12'h01C;
    localparam logic [11:0] ADDR_INT_EN = 12'h020;

    // enable register bit positions
    localparam int EN_SER_CNT = 0;
    localparam int EN_INT = 1;
    localparam int EN_LDRV = 2;
    localparam int EN_SO = 3;
    localparam int EN_ISRC0 = 4;
    localparam int EN_ISRC1 = 5;
    localparam int EN_CNT_SRC = 6;
    localparam int EN_RDRV = 7;
    // ctrl bit of the ports register
    localparam int PORTS_SKL = 20;

    localparam int IRQ_OVF = 0;
    localparam int IRQ_EXT = 1;
    localparam int IRQ_W = 2;

    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [1:0] ISRC_FALL = 2'h0;
    localparam logic [1:0] ISRC_EDGE = 2'h2;
    localparam logic [1:0] ISRC_TOVF = 2'h3;

    typedef struct packed {
        logic [3:0] d;
        logic [3:0] g;
        logic [3:0] h;
        logic [7:0] r;
        logic r_oe;
        logic [7:0] l;
        logic l_oe;
    } port_out_s;

    typedef struct packed {
        logic clear;
        logic carry;
        logic [3:0] acc;
        logic [5:0] ram_addr;
        logic [10:0] pc;
    } core_init_s;

    typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_RESET} pin_st_e;
endpackage : tbc_pkg

// ==== verilog/time_base_counter.sv ====
// time base counter with overflow latch, event counting and reset sequencing
`timescale 1ns/1ns
module time_base_counter
    import tbc_pkg::*;
#(
    parameter int DIV = CYC_DIV,
    parameter bit EXT_TIMER = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic reset_pin_n,
    input wire logic event_pulse_input,
    input wire logic interrupt_pulse_input,
    input wire logic [1:0] edge_pins,
    output logic shift_clock_pin,
    output logic serial_out,
    output port_out_s ports,
    output core_init_s core_init,
    output logic irq
);
    localparam int HALF = DIV / 2;
    localparam int CW = $clog2(DIV);
    localparam int SW = 5;

    logic [SW-1:0] sync1_r, sync2_r;
    logic [CW-1:0] cyc_r;
    logic tick;
    pin_st_e pin_st_r;
    logic [3:0] rst_len_r;
    logic pin_rst, long_rst;
    logic [7:0] enable_r;
    logic skl_r;
    logic [PRE_BITS-1:0] pre_r;
    logic [T_BITS-1:0] t_r;
    logic ovf_flag_r;
    logic [SW-1:0] samp_r;
    logic ev_fall, in1_fall, in1_edge;
    logic t_inc, overflow;
    logic [1:0] edge_latch_r;
    logic [IRQ_W-1:0] stat_r, irq_en_r, irq_ev;
    logic [7:0] q_r;
    logic [3:0] d_r, g_r, h_r;
    logic [7:0] r_r;
    logic acc_phase, wr, rd, hit;
    logic [31:0] rdata;
    logic src_evt;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
        return a == ref_a;
    endfunction : is_addr

    // pin synchronisers; only stage two is read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else begin
            sync1_r <= {edge_pins, interrupt_pulse_input, event_pulse_input, reset_pin_n};
            sync2_r <= sync1_r;
        end
    end

    // instruction cycle divider
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_r <= '0;
        end else if (tick) begin
            cyc_r <= '0;
        end else begin
            cyc_r <= cyc_r + CW'(1);
        end
    end
    assign tick = (cyc_r == CW'(DIV - 1));

    // reset pin qualification, counted in instruction cycles
    // a low pulse shorter than three ticks bumps the count and enters ST_LOW but never resets
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_st_r <= ST_RUN;
            rst_len_r <= '0;
        end else if (sync2_r[0]) begin
            pin_st_r <= ST_RUN;
            rst_len_r <= '0;
        end else if (tick) begin
            if (rst_len_r != 4'(RST_LONG_CYC)) begin
                rst_len_r <= rst_len_r + 4'd1;
            end
            if (rst_len_r >= 4'(RST_SHORT_CYC - 1)) begin
                pin_st_r <= ST_RESET;
            end else begin
                pin_st_r <= ST_LOW;
            end
        end
    end
    assign pin_rst = (pin_st_r == ST_RESET);
    assign long_rst = (rst_len_r == 4'(RST_LONG_CYC));

    // apb decode: one wait state so read data leaves a flop
    assign acc_phase = psel && penable;
    assign wr = acc_phase && pready && pwrite;
    assign rd = acc_phase && pready && !pwrite;
    assign hit = is_addr(paddr, ADDR_ENABLE) || is_addr(paddr, ADDR_TIMER)
        || is_addr(paddr, ADDR_TSTCLR) || is_addr(paddr, ADDR_PORTS)
        || is_addr(paddr, ADDR_QREG) || is_addr(paddr, ADDR_INLATCH)
        || is_addr(paddr, ADDR_INT_STAT) || is_addr(paddr, ADDR_INT_CLR)
        || is_addr(paddr, ADDR_INT_EN);

    always_comb begin
        rdata = '0;
        unique case (1'b1)
            is_addr(paddr, ADDR_ENABLE): rdata[7:0] = enable_r;
            is_addr(paddr, ADDR_TIMER): rdata[9:0] = {t_r, pre_r};
            is_addr(paddr, ADDR_TSTCLR): rdata[0] = ovf_flag_r;
            is_addr(paddr, ADDR_PORTS): rdata = {11'h000, skl_r, r_r, h_r, g_r, d_r};
            is_addr(paddr, ADDR_QREG): rdata[7:0] = q_r;
            is_addr(paddr, ADDR_INLATCH): rdata[1:0] = edge_latch_r;
            is_addr(paddr, ADDR_INT_STAT): rdata[IRQ_W-1:0] = stat_r;
            is_addr(paddr, ADDR_INT_EN): rdata[IRQ_W-1:0] = irq_en_r;
            default: rdata = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (acc_phase && !pready) begin
            pready <= 1'b1;
            prdata <= rdata;
            pslverr <= !hit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // enable register and clock latch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= EN_RESET;
            skl_r <= 1'b1;
        end else if (pin_rst) begin
            enable_r <= EN_RESET;
            skl_r <= 1'b1;
        end else if (wr && hit) begin
            if (is_addr(paddr, ADDR_ENABLE)) begin
                enable_r <= pwdata[7:0];
            end
            if (is_addr(paddr, ADDR_PORTS)) begin
                skl_r <= pwdata[PORTS_SKL];
            end
        end
    end
    // without extended access the source stays on the prescaler
    assign src_evt = EXT_TIMER && enable_r[EN_CNT_SRC];

    // sample pins once per instruction cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            samp_r <= '1;
        end else if (tick) begin
            samp_r <= sync2_r;
        end
    end
    // a pulse shorter than one cycle can fall between samples
    assign ev_fall = tick && samp_r[1] && !sync2_r[1];
    assign in1_fall = tick && samp_r[2] && !sync2_r[2];
    assign in1_edge = tick && (samp_r[2] != sync2_r[2]);

    assign t_inc = src_evt ? ev_fall : (tick && (&pre_r));
    assign overflow = t_inc && (&t_r);

    // ten-bit time base: prescaler plus upper eight bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= '0;
            t_r <= '0;
        end else if (EXT_TIMER ? pin_rst : long_rst) begin
            pre_r <= '0;
            t_r <= '0;
        end else begin
            if (tick && !src_evt) begin
                pre_r <= pre_r + PRE_BITS'(1);
            end
            if (EXT_TIMER && wr && is_addr(paddr, ADDR_TIMER)) begin
                t_r <= pwdata[9:2];
            end else if (t_inc) begin
                t_r <= t_r + T_BITS'(1);
            end
        end
    end

    // overflow latch; a new overflow beats the test-and-clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag_r <= 1'b0;
        end else if (overflow || (!EXT_TIMER && long_rst)) begin
            ovf_flag_r <= 1'b1;
        end else if (rd && is_addr(paddr, ADDR_TSTCLR)) begin
            ovf_flag_r <= 1'b0;
        end
    end

    // edge latches for the two extra inputs, cleared by reading them
    // an edge in the cycle of the read survives, so the set wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            edge_latch_r <= '0;
        end else if (pin_rst) begin
            edge_latch_r <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (tick && samp_r[3+i] && !sync2_r[3+i]) begin
                    edge_latch_r[i] <= 1'b1;
                end else if (rd && is_addr(paddr, ADDR_INLATCH)) begin
                    edge_latch_r[i] <= 1'b0;
                end
            end
        end
    end

    // output latches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            d_r <= '0;
            g_r <= '0;
            h_r <= '0;
            r_r <= '0;
            q_r <= '0;
        end else if (pin_rst) begin
            d_r <= '0;
            g_r <= '0;
            h_r <= '0;
            r_r <= '0;
            q_r <= '0;
        end else if (wr && is_addr(paddr, ADDR_PORTS)) begin
            {r_r, h_r, g_r, d_r} <= pwdata[19:0];
        end else if (wr && is_addr(paddr, ADDR_QREG)) begin
            q_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ports <= '0;
        end else begin
            ports <= '{d: d_r, g: g_r, h: h_r, r: r_r, r_oe: enable_r[EN_RDRV],
                l: q_r, l_oe: enable_r[EN_LDRV]};
        end
    end

    // shift clock runs at cycle rate during reset or when enabled as a clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_clock_pin <= 1'b0;
            serial_out <= 1'b0;
        end else begin
            if (pin_st_r != ST_RUN || (!enable_r[EN_SER_CNT] && skl_r)) begin
                shift_clock_pin <= (cyc_r < CW'(HALF));
            end else begin
                shift_clock_pin <= enable_r[EN_SER_CNT] && skl_r;
            end
            // shift datapath lives elsewhere; shift mode drives the EN_SO bit here
            serial_out <= enable_r[EN_SER_CNT] && enable_r[EN_SO];
        end
    end

    // core register clear request, held for the whole reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_init <= '{clear: 1'b1, default: '0};
        end else begin
            core_init <= '{clear: pin_rst, default: '0};
        end
    end

    // interrupts
    // a clear written in the cycle of an event leaves that event pending
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_OVF] = overflow;
        if (enable_r[EN_INT]) begin
            unique case (enable_r[EN_ISRC1:EN_ISRC0])
                ISRC_FALL: irq_ev[IRQ_EXT] = in1_fall;
                ISRC_EDGE: irq_ev[IRQ_EXT] = in1_edge;
                ISRC_TOVF: irq_ev[IRQ_EXT] = overflow;
                default: irq_ev[IRQ_EXT] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= '0;
            irq_en_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wr && is_addr(paddr, ADDR_INT_CLR)) begin
                stat_r <= irq_ev | (stat_r & ~pwdata[IRQ_W-1:0]);
            end else begin
                stat_r <= irq_ev | stat_r;
            end
            if (wr && is_addr(paddr, ADDR_INT_EN)) begin
                irq_en_r <= pwdata[IRQ_W-1:0];
            end
            irq <= |(stat_r & irq_en_r);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ovf_sets_flag_a: assert property (overflow && !pin_rst |=> ovf_flag_r)
        else $error("overflow did not set flag");
    test_clears_a: assert property (rd && is_addr(paddr, ADDR_TSTCLR) && !overflow
        && !long_rst |=> !ovf_flag_r)
        else $error("test and clear left flag set");
    wrap_1024_a: assert property (!src_evt && tick && !pin_rst && !long_rst
        && !(wr && is_addr(paddr, ADDR_TIMER))
        |=> {t_r, pre_r} == $past({t_r, pre_r}) + 1'b1)
        else $error("ten-bit count did not step");
    evt_count_a: assert property (src_evt && ev_fall && !(&t_r) && !pin_rst
        && !wr |=> t_r == $past(t_r) + 8'h01)
        else $error("event edge not counted");
    evt_frozen_a: assert property (src_evt && !ev_fall && !wr && !pin_rst
        |=> $stable(t_r) && $stable(pre_r))
        else $error("counter moved without event");
    timer_write_a: assert property (EXT_TIMER && wr && is_addr(paddr, ADDR_TIMER)
        && !pin_rst |=> t_r == $past(pwdata[9:2]))
        else $error("timer write lost");
    sk_toggle_a: assert property (pin_st_r != ST_RUN && cyc_r == CW'(HALF)
        && !sync2_r[0] |=> !shift_clock_pin ##(HALF) shift_clock_pin || sync2_r[0])
        else $error("shift clock not at cycle rate");
    short_rst_clr_a: assert property (EXT_TIMER && pin_rst |=> t_r == '0 && pre_r == '0)
        else $error("counter not cleared in reset");
    port_reset_a: assert property (pin_rst |=> ##1 ports.d == '0 && ports.g == '0
        && !ports.l_oe && !ports.r_oe)
        else $error("ports not cleared by reset");
    irq_level_a: assert property (|(stat_r & irq_en_r) |=> irq)
        else $error("interrupt not raised");

    // bus answer, reset values, edge latch and held-low outputs
    irq_drop_a: assert property (!(|(stat_r & irq_en_r)) |=> !irq)
        else $error("interrupt stuck high");
    reset_init_a: assert property (pin_rst |=> enable_r == EN_RESET && skl_r)
        else $error("enable or clock latch not reset");
    so_low_a: assert property (!enable_r[EN_SER_CNT] |=> !serial_out)
        else $error("serial output not held low");
    edge_latch_a: assert property (tick && samp_r[3] && !sync2_r[3] && !pin_rst
        |=> edge_latch_r[0])
        else $error("input edge not latched");
    bus_answer_a: assert property (acc_phase && !pready |=> pready && prdata == $past(rdata))
        else $error("bus answer late or wrong");
    bus_error_a: assert property (pslverr |-> pready && !hit)
        else $error("error response on mapped address");

    ovf_seen_c: cover property (overflow ##[1:50] rd && is_addr(paddr, ADDR_TSTCLR));
    evt_mode_c: cover property (src_evt && ev_fall);
    pin_rst_c: cover property (pin_st_r == ST_LOW ##[1:400] pin_rst);
    irq_c: cover property (irq);
    evt_ovf_c: cover property (src_evt && overflow);
endmodule : time_base_counter

// ==== dv/ext_src.sv ====
// far-side model: reset pin, event pulse source and interrupt pins
`timescale 1ns/1ns
module ext_src
    import tbc_pkg::*;
#(
    parameter int DIV = 4
) (
    // clock
    input wire logic mclk,
    // pins towards the device, idle high like pulled-up lines
    output logic reset_pin_n,
    output logic event_pulse_input,
    output logic interrupt_pulse_input,
    output logic [1:0] edge_pins
);
    initial begin
        reset_pin_n = 1'b1;
        event_pulse_input = 1'b1;
        interrupt_pulse_input = 1'b1;
        edge_pins = 2'h3;
    end

    // reset pin level; the bench decides how long it stays low
    task rst_set(input logic lvl);
        @(posedge mclk);
        reset_pin_n <= lvl;
    endtask : rst_set

    // low and high phases of two cycles each so no edge is missed
    task pulses(input int n);
        repeat (n) begin
            repeat (2 * DIV) @(posedge mclk);
            event_pulse_input <= 1'b0;
            repeat (2 * DIV) @(posedge mclk);
            event_pulse_input <= 1'b1;
        end
        repeat (2 * DIV) @(posedge mclk);
    endtask : pulses

    task int_pulse;
        @(posedge mclk);
        interrupt_pulse_input <= 1'b0;
        edge_pins <= 2'h0;
        repeat (2 * DIV) @(posedge mclk);
        interrupt_pulse_input <= 1'b1;
        edge_pins <= 2'h3;
        repeat (4 * DIV) @(posedge mclk);
    endtask : int_pulse
endmodule : ext_src

// ==== dv/test_time_base_counter.sv ====
// self-checking bench for the time base counter block
`timescale 1ns/1ns
module test_time_base_counter;
    import tbc_pkg::*;
    localparam int DV = 4;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic event_pulse_input, reset_pin_n, interrupt_pulse_input;
    logic shift_clock_pin, serial_out, irq;
    logic [1:0] edge_pins;
    port_out_s ports;
    core_init_s core_init;
    int fails, comparisons, r;
    int cyc = 0;
    logic [7:0] t0;

    time_base_counter #(.DIV(DV)) u_time_base_counter (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_n(reset_pin_n), .event_pulse_input(event_pulse_input),
        .interrupt_pulse_input(interrupt_pulse_input), .edge_pins(edge_pins),
        .shift_clock_pin(shift_clock_pin), .serial_out(serial_out), .ports(ports),
        .core_init(core_init), .irq(irq));

    ext_src u_ext_src (
        .mclk(mclk), .reset_pin_n(reset_pin_n), .event_pulse_input(event_pulse_input),
        .interrupt_pulse_input(interrupt_pulse_input), .edge_pins(edge_pins));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // the limit covers the full overflow period plus every other test
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; the request is held until pready is sampled high
    // only the cycle limit ends a wait that never sees pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // rising edges of the shift clock over n mclk cycles
    task cnt_sk(input int n);
        logic prev;
        prev = shift_clock_pin;
        r = 0;
        repeat (n) begin
            @(posedge mclk);
            if (prev === 1'b0 && shift_clock_pin === 1'b1) begin
                r++;
            end
            prev = shift_clock_pin;
        end
    endtask : cnt_sk

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        fails = 0;
        comparisons = 0;
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        // power-up state
        rd(ADDR_ENABLE);
        chk("enable", q, 32'h0000_0000);
        rd(ADDR_PORTS);
        chk("ports reg", q, 32'h0010_0000);
        rd(ADDR_TIMER);
        chk("timer", {24'h00_0000, q[9:2]}, 32'h0000_0000);
        chk("core", {core_init.carry, core_init.acc, core_init.ram_addr, core_init.pc}, 0);
        chk("pins", {ports, serial_out, irq}, 0);
        cnt_sk(40);
        chk("sk period", r, 10);
        rd(12'h0fc);
        chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
        $display("test power-up done");
        // full period from a cleared count
        wr(ADDR_TIMER, 32'h0000_0000);
        rd(ADDR_TSTCLR);
        wr(ADDR_INT_CLR, 32'h0000_0003);
        repeat (4040) @(posedge mclk);
        rd(ADDR_TSTCLR);
        chk("early flag", q, 32'h0000_0000);
        repeat (60) @(posedge mclk);
        rd(ADDR_TSTCLR);
        chk("flag set", q, 32'h0000_0001);
        rd(ADDR_TSTCLR);
        chk("flag cleared", q, 32'h0000_0000);
        rd(ADDR_INT_STAT);
        chk("status ovf", q[0], 1'b1);
        $display("test period done");
        // event counting
        wr(ADDR_ENABLE, 32'h0000_0040);
        wr(ADDR_TIMER, 32'h0000_0014);
        repeat (40) @(posedge mclk);
        rd(ADDR_TIMER);
        chk("held", q[9:2], 8'h05);
        u_ext_src.pulses(3);
        rd(ADDR_TIMER);
        chk("events", q[9:2], 8'h08);
        wr(ADDR_TIMER, 32'h0000_03f8);
        rd(ADDR_TSTCLR);
        u_ext_src.pulses(2);
        rd(ADDR_TSTCLR);
        chk("event ovf", q, 32'h0000_0001);
        wr(ADDR_ENABLE, 32'h0000_0000);
        rd(ADDR_TIMER);
        t0 = q[9:2];
        repeat (61) @(posedge mclk);
        rd(ADDR_TIMER);
        chk("tb step", 32'(q[9:2] - t0 >= 3 && q[9:2] - t0 <= 5), 1);
        $display("test events done");
        // pin interrupt: raise, mask, enable, clear
        wr(ADDR_INT_EN, 32'h0000_0000);
        wr(ADDR_INT_CLR, 32'h0000_0003);
        wr(ADDR_ENABLE, 32'h0000_0002);
        u_ext_src.int_pulse();
        rd(ADDR_INT_STAT);
        chk("pin event", {irq, q[1]}, 2'b01);
        rd(ADDR_INLATCH);
        chk("edge latch", q, 32'h0000_0003);
        rd(ADDR_INLATCH);
        chk("edge clear", q, 32'h0000_0000);
        wr(ADDR_INT_EN, 32'h0000_0002);
        repeat (3) @(posedge mclk);
        chk("irq on", irq, 1'b1);
        wr(ADDR_INT_CLR, 32'h0000_0002);
        repeat (3) @(posedge mclk);
        chk("irq off", irq, 1'b0);
        // any-edge source, serial counter mode and the l port latch
        wr(ADDR_QREG, 32'h0000_00a5);
        wr(ADDR_ENABLE, 32'h0000_002b);
        wr(ADDR_INT_CLR, 32'h0000_0003);
        u_ext_src.int_pulse();
        rd(ADDR_INT_STAT);
        chk("edge event", q[1], 1'b1);
        rd(ADDR_QREG);
        chk("q reg", q, 32'h0000_00a5);
        chk("so sk l", {serial_out, shift_clock_pin, ports.l}, 32'h0000_03a5);
        $display("test interrupt done");
        // reset pin: a short pulse is ignored, a long one resets
        wr(ADDR_PORTS, 32'h0000_0fff);
        wr(ADDR_ENABLE, 32'h0000_00c4);
        repeat (3) @(posedge mclk);
        chk("drive", {ports.d, ports.l_oe, ports.r_oe}, 6'h3f);
        // five samples low hold at most two ticks, below the three-tick limit
        u_ext_src.rst_set(1'b0);
        repeat (DV) @(posedge mclk);
        u_ext_src.rst_set(1'b1);
        repeat (20) @(posedge mclk);
        rd(ADDR_ENABLE);
        chk("short pulse", q, 32'h0000_00c4);
        u_ext_src.rst_set(1'b0);
        // the pin needs the synchroniser and one tick before the clock runs
        repeat (2 * DV) @(posedge mclk);
        cnt_sk(40);
        chk("sk in reset", r, 10);
        chk("clear", core_init.clear, 1'b1);
        u_ext_src.rst_set(1'b1);
        repeat (6) @(posedge mclk);
        rd(ADDR_TIMER);
        chk("t cleared", 32'(q[9:2] <= 8'h01), 1);
        rd(ADDR_ENABLE);
        chk("en cleared", q, 32'h0000_0000);
        rd(ADDR_PORTS);
        chk("ports cleared", q, 32'h0010_0000);
        chk("pins off", {ports.d, ports.l_oe, ports.r_oe, serial_out}, 0);
        $display("test reset pin done");
        end_sim();
    end
endmodule : test_time_base_counter
